// ==== include/rx_profile_pkg.sv ====
// shared constants, carriers and helpers for the receiver mode profile bank, modes 6 to 10
`default_nettype none

package rx_profile_pkg;

	// ----------------------------------------
	// register port geometry
	// ----------------------------------------
	localparam int unsigned ADDR_W     = 12;                 // register address width of the internal port
	localparam int unsigned DATA_W     = 8;                  // every register is one byte
	localparam int unsigned MODE_COUNT = 5;                  // stored modes 6, 7, 8, 9 and 10
	localparam int unsigned SLOT_COUNT = 3;                  // enable, gain 1/2, gain 3/4

	typedef logic [ADDR_W-1:0] reg_addr_t;                  // register address
	typedef logic [DATA_W-1:0] reg_data_t;                  // register byte
	typedef logic [3:0]        mode_num_t;                  // stored mode number as software counts it

	// ----------------------------------------
	// register offsets
	// ----------------------------------------
	localparam reg_addr_t MODE6_PATH_EN_OFS   = 12'h052;     // mode 6 enables
	localparam reg_addr_t MODE6_GAIN12_OFS    = 12'h053;     // mode 6 gains, channels 1 and 2
	localparam reg_addr_t MODE6_GAIN34_OFS    = 12'h054;     // mode 6 gains, channels 3 and 4
	localparam reg_addr_t MODE7_PATH_EN_OFS   = 12'h055;     // mode 7 enables
	localparam reg_addr_t MODE7_GAIN12_OFS    = 12'h056;     // mode 7 gains, channels 1 and 2
	localparam reg_addr_t MODE7_GAIN34_OFS    = 12'h057;     // mode 7 gains, channels 3 and 4
	localparam reg_addr_t MODE8_PATH_EN_OFS   = 12'h058;     // mode 8 enables
	localparam reg_addr_t MODE8_GAIN12_OFS    = 12'h059;     // mode 8 gains, channels 1 and 2
	localparam reg_addr_t MODE8_GAIN34_OFS    = 12'h05A;     // mode 8 gains, channels 3 and 4
	localparam reg_addr_t MODE9_PATH_EN_OFS   = 12'h05B;     // mode 9 enables
	localparam reg_addr_t MODE9_GAIN12_OFS    = 12'h05C;     // mode 9 gains, channels 1 and 2
	localparam reg_addr_t MODE9_GAIN34_OFS    = 12'h05D;     // mode 9 gains, channels 3 and 4
	localparam reg_addr_t MODE10_PATH_EN_OFS  = 12'h05E;     // mode 10 enables, the last byte of this slice
	localparam reg_addr_t MODE_STRIDE         = 12'h003;     // three consecutive bytes per stored mode

	// ----------------------------------------
	// field positions inside the bytes
	// ----------------------------------------
	localparam int unsigned EN_MAIN_SPLIT_BIT = 6;           // main active splitter
	localparam int unsigned EN_PAIR_A_BIT     = 5;           // channel 1 to 2 splitter
	localparam int unsigned EN_PAIR_B_BIT     = 4;           // channel 3 to 4 splitter
	localparam int unsigned EN_CHAN_MSB       = 3;           // channel 1 enable; channel 4 at bit 0
	localparam int unsigned GAIN_HI_LSB       = 4;           // lower-numbered channel in [6:4]
	localparam int unsigned GAIN_LO_LSB       = 0;           // higher-numbered channel in [2:0]
	localparam int unsigned GAIN_W            = 3;           // gain code width

	// ----------------------------------------
	// carriers
	// ----------------------------------------
	typedef logic [GAIN_W-1:0] gain_code_t;                 // one channel gain code

	typedef struct packed {
		logic       mainSplitterOn;                      // bit 6
		logic       pairASplitterOn;                     // bit 5, channels 1 to 2
		logic       pairBSplitterOn;                     // bit 4, channels 3 to 4
		logic [3:0] chanOn;                              // [3] channel 1 ... [0] channel 4
	} path_en_s;

	typedef struct packed {
		path_en_s   pathEn;                              // splitter and channel enables
		gain_code_t chanOneGain;                         // channel 1 gain code
		gain_code_t chanTwoGain;                         // channel 2 gain code
		gain_code_t chanThreeGain;                       // channel 3 gain code
		gain_code_t chanFourGain;                        // channel 4 gain code
	} profile_s;

	typedef struct packed {
		logic       hit;                                 // address falls in this slice
		logic [2:0] modeIdx;                             // 0 is mode 6 ... 4 is mode 10
		logic [1:0] slot;                                // 0 enables, 1 gain 1/2, 2 gain 3/4
	} reg_sel_s;

	// ----------------------------------------
	// reset values
	// ----------------------------------------
	localparam gain_code_t GAIN_RST         = 3'h4;          // mid-range gain default
	localparam path_en_s   MODE6_PATH_RST   = 7'h68;         // main, pair A, channel 1
	localparam path_en_s   MODE7_PATH_RST   = 7'h64;         // main, pair A, channel 2
	localparam path_en_s   MODE8_PATH_RST   = 7'h52;         // main, pair B, channel 3
	localparam path_en_s   MODE9_PATH_RST   = 7'h51;         // main, pair B, channel 4
	localparam path_en_s   MODE10_PATH_RST  = 7'h7F;         // all splitters and channels on
	localparam profile_s   IDLE_PROFILE     = 19'h00000;     // nothing applied yet: receiver off
	localparam mode_num_t  FIRST_MODE       = 4'h6;          // lowest mode held here
	localparam mode_num_t  NO_MODE          = 4'h0;          // no profile applied

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	// map an address to its mode and slot; mode 10 owns only its enable byte here
	function automatic reg_sel_s decode_addr(input reg_addr_t addr);
		reg_sel_s  sel;
		reg_addr_t base;
		sel  = '0;
		base = MODE6_PATH_EN_OFS;
		for (int k = 0; k < MODE_COUNT; k++) begin
			for (int s = 0; s < SLOT_COUNT; s++) begin
				if (addr == base + reg_addr_t'(s) && (k < MODE_COUNT - 1 || s == 0)) begin
					sel.hit     = 1'b1;
					sel.modeIdx = 3'(k);
					sel.slot    = 2'(s);
				end
			end
			base = base + MODE_STRIDE;
		end
		return sel;
	endfunction

	// build a gain byte with both reserved bits at zero
	function automatic reg_data_t pack_gain(input gain_code_t hi, input gain_code_t lo);
		return {1'b0, hi, 1'b0, lo};
	endfunction

	// build an enable byte with the reserved top bit at zero
	function automatic reg_data_t pack_path(input path_en_s en);
		return {1'b0, en};
	endfunction

endpackage

`default_nettype wire

// ==== hw/mode_profile_slot.sv ====
// one stored receiver mode: enable byte and two gain bytes
`default_nettype none

module mode_profile_slot
	import rx_profile_pkg::*;
#(
	parameter profile_s RESET_PROFILE = IDLE_PROFILE,  // power-on contents of this mode
	parameter bit       HAS_GAINS     = 1'b1           // mode 10 keeps its gains in another slice
) (
	input  wire logic                   core_clk,
	input  wire logic                   reset,
	input  wire logic [2:0]             slotWrite,
	input  wire rx_profile_pkg::reg_data_t wrData,
	output var  rx_profile_pkg::profile_s  profile
);

	// ----------------------------------------
	// storage
	// ----------------------------------------
	profile_s profile_reg;                              // stored profile
	profile_s profile_next;                             // its next value

	// write merge; reserved bits are dropped, not stored
	always_comb begin
		profile_next = profile_reg;
		if (slotWrite[0]) begin
			profile_next.pathEn = path_en_s'(wrData[6:0]);
		end
		if (HAS_GAINS && slotWrite[1]) begin
			profile_next.chanOneGain = wrData[GAIN_HI_LSB +: GAIN_W];
			profile_next.chanTwoGain = wrData[GAIN_LO_LSB +: GAIN_W];
		end
		if (HAS_GAINS && slotWrite[2]) begin
			profile_next.chanThreeGain = wrData[GAIN_HI_LSB +: GAIN_W];
			profile_next.chanFourGain  = wrData[GAIN_LO_LSB +: GAIN_W];
		end
	end

	// synchronous reset loads the documented defaults
	always_ff @(posedge core_clk) begin
		if (reset) begin
			profile_reg <= RESET_PROFILE;
		end else begin
			profile_reg <= profile_next;
		end
	end

	assign profile = profile_reg;

endmodule

`default_nettype wire

// ==== hw/rx_mode_profile_regs.sv ====
// receiver mode profile register bank for stored modes 6 to 10
`default_nettype none

module rx_mode_profile_regs
	import rx_profile_pkg::*;
(
	input  wire logic                      core_clk,
	input  wire logic                      reset,
	// register port from the serial control decoder
	input  wire rx_profile_pkg::reg_addr_t regAddr,
	input  wire logic                      regWrite,
	input  wire rx_profile_pkg::reg_data_t regWrData,
	input  wire logic                      regRead,
	output var  rx_profile_pkg::reg_data_t regRdData,
	output var  logic                      regRdValid,
	output var  logic                      regRdMiss,
	// mode sequencer request
	input  wire logic                      applyStrobe,
	input  wire rx_profile_pkg::mode_num_t applyMode,
	// profile driven into the receiver
	output var  rx_profile_pkg::profile_s  activeProfile,
	output var  rx_profile_pkg::mode_num_t activeMode,
	output var  logic                      applyMiss
);

	// ----------------------------------------
	// address decode
	// ----------------------------------------
	reg_sel_s regSel;                                    // mode and slot of the current address
	logic     [2:0] slotWrite [MODE_COUNT];              // per-mode write strobes

	// one decoder feeds both the write strobes and the read mux
	always_comb begin
		regSel = decode_addr(regAddr);
	end

	// turn the decoded address into one strobe per stored byte
	always_comb begin
		for (int k = 0; k < MODE_COUNT; k++) begin
			slotWrite[k] = 3'h0;
			if (regWrite && regSel.hit && regSel.modeIdx == 3'(k)) begin
				slotWrite[k] = 3'(1 << regSel.slot);
			end
		end
	end

	// ----------------------------------------
	// stored profiles
	// ----------------------------------------
	profile_s storedProfile [MODE_COUNT];                // one per mode, index 0 is mode 6

	// mode 6: channel 1 path, gains mid-range
	mode_profile_slot #(
		.RESET_PROFILE ({MODE6_PATH_RST, GAIN_RST, GAIN_RST, GAIN_RST, GAIN_RST}),
		.HAS_GAINS     (1'b1)
	) modeSixSlot (
		.core_clk  (core_clk),
		.reset     (reset),
		.slotWrite (slotWrite[0]),
		.wrData    (regWrData),
		.profile   (storedProfile[0])
	);

	// mode 7: channel 2 path, gains mid-range
	mode_profile_slot #(
		.RESET_PROFILE ({MODE7_PATH_RST, GAIN_RST, GAIN_RST, GAIN_RST, GAIN_RST}),
		.HAS_GAINS     (1'b1)
	) modeSevenSlot (
		.core_clk  (core_clk),
		.reset     (reset),
		.slotWrite (slotWrite[1]),
		.wrData    (regWrData),
		.profile   (storedProfile[1])
	);

	// mode 8: channel 3 path, gains mid-range
	mode_profile_slot #(
		.RESET_PROFILE ({MODE8_PATH_RST, GAIN_RST, GAIN_RST, GAIN_RST, GAIN_RST}),
		.HAS_GAINS     (1'b1)
	) modeEightSlot (
		.core_clk  (core_clk),
		.reset     (reset),
		.slotWrite (slotWrite[2]),
		.wrData    (regWrData),
		.profile   (storedProfile[2])
	);

	// mode 9: channel 4 path, gains mid-range
	mode_profile_slot #(
		.RESET_PROFILE ({MODE9_PATH_RST, GAIN_RST, GAIN_RST, GAIN_RST, GAIN_RST}),
		.HAS_GAINS     (1'b1)
	) modeNineSlot (
		.core_clk  (core_clk),
		.reset     (reset),
		.slotWrite (slotWrite[3]),
		.wrData    (regWrData),
		.profile   (storedProfile[3])
	);

	// mode 10: only the enable byte lives here; its gain bits stay frozen
	mode_profile_slot #(
		.RESET_PROFILE ({MODE10_PATH_RST, GAIN_RST, GAIN_RST, GAIN_RST, GAIN_RST}),
		.HAS_GAINS     (1'b0)
	) modeTenSlot (
		.core_clk  (core_clk),
		.reset     (reset),
		.slotWrite (slotWrite[4]),
		.wrData    (regWrData),
		.profile   (storedProfile[4])
	);

	// ----------------------------------------
	// read-back path
	// ----------------------------------------
	reg_data_t rdData_reg;                               // byte returned to the port
	reg_data_t rdData_next;
	logic      rdValid_reg;                              // one-cycle answer marker
	logic      rdValid_next;
	logic      rdMiss_reg;                               // address outside this slice
	logic      rdMiss_next;
	profile_s  readProfile;                              // profile addressed by the read

	// pick the addressed byte; reserved bits come back as zero
	always_comb begin
		readProfile  = storedProfile[0];
		for (int k = 0; k < MODE_COUNT; k++) begin
			if (regSel.modeIdx == 3'(k)) begin
				readProfile = storedProfile[k];
			end
		end
		rdData_next  = 8'h00;
		rdValid_next = regRead;
		rdMiss_next  = regRead && !regSel.hit;
		if (regRead && regSel.hit) begin
			unique case (regSel.slot)
				2'h0: begin
					rdData_next = pack_path(readProfile.pathEn);
				end
				2'h1: begin
					rdData_next = pack_gain(readProfile.chanOneGain, readProfile.chanTwoGain);
				end
				2'h2: begin
					rdData_next = pack_gain(readProfile.chanThreeGain, readProfile.chanFourGain);
				end
				default: begin
					rdData_next = 8'h00;             // slot code 3 is never decoded
				end
			endcase
		end
	end

	// register the answer so every port output comes from a flop
	always_ff @(posedge core_clk) begin
		if (reset) begin
			rdData_reg  <= 8'h00;
			rdValid_reg <= 1'b0;
			rdMiss_reg  <= 1'b0;
		end else begin
			rdData_reg  <= rdData_next;
			rdValid_reg <= rdValid_next;
			rdMiss_reg  <= rdMiss_next;
		end
	end

	// ----------------------------------------
	// profile application
	// ----------------------------------------
	profile_s  active_reg;                               // profile driving the receiver
	profile_s  active_next;
	mode_num_t activeMode_reg;                           // mode number now applied
	mode_num_t activeMode_next;
	logic      applyMiss_reg;                            // request named a mode not held here
	logic      applyMiss_next;
	logic      applyInRange;                             // request falls in modes 6 to 10
	logic [2:0] applyIdx;                                // slot index of the request

	// copy the chosen stored profile; later writes wait for the next apply
	always_comb begin
		active_next     = active_reg;
		activeMode_next = activeMode_reg;
		applyMiss_next  = 1'b0;
		applyInRange    = applyMode >= FIRST_MODE && applyMode < FIRST_MODE + 4'(MODE_COUNT);
		applyIdx        = 3'(applyMode - FIRST_MODE);
		if (applyStrobe) begin
			if (applyInRange) begin
				active_next.pathEn = storedProfile[applyIdx].pathEn;
				// mode 10 gains are owned elsewhere, so the current gains hold
				if (applyIdx != 3'(MODE_COUNT - 1)) begin
					active_next = storedProfile[applyIdx];
				end
				activeMode_next = applyMode;
			end else begin
				applyMiss_next = 1'b1;               // out-of-slice request flags applyMiss and leaves profile and mode alone
			end
		end
	end

	// hold the applied profile until the next accepted request
	always_ff @(posedge core_clk) begin
		if (reset) begin
			active_reg     <= IDLE_PROFILE;
			activeMode_reg <= NO_MODE;
			applyMiss_reg  <= 1'b0;
		end else begin
			active_reg     <= active_next;
			activeMode_reg <= activeMode_next;
			applyMiss_reg  <= applyMiss_next;
		end
	end

	// ----------------------------------------
	// outputs
	// ----------------------------------------
	assign regRdData     = rdData_reg;
	assign regRdValid    = rdValid_reg;
	assign regRdMiss     = rdMiss_reg;
	assign activeProfile = active_reg;
	assign activeMode    = activeMode_reg;
	assign applyMiss     = applyMiss_reg;

endmodule

`default_nettype wire

// ==== verification/rx_mode_profile_regs_chk.sv ====
// assertion checker for the receiver mode profile bank
`default_nettype none

module rx_mode_profile_regs_chk
	import rx_profile_pkg::*;
(
	input wire logic                      core_clk,
	input wire logic                      reset,
	input wire rx_profile_pkg::reg_addr_t regAddr,
	input wire logic                      regWrite,
	input wire rx_profile_pkg::reg_data_t regWrData,
	input wire logic                      regRead,
	input wire rx_profile_pkg::reg_data_t regRdData,
	input wire logic                      regRdValid,
	input wire logic                      regRdMiss,
	input wire logic                      applyStrobe,
	input wire rx_profile_pkg::mode_num_t applyMode,
	input wire rx_profile_pkg::profile_s  activeProfile,
	input wire rx_profile_pkg::mode_num_t activeMode,
	input wire logic                      applyMiss
);
	timeunit 1ns;
	timeprecision 1ps;

	// ----------------------------------------
	// one clock domain
	// ----------------------------------------
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (reset);

	// ----------------------------------------
	// register port
	// ----------------------------------------
	a_rd_answer: assert property (regRead |=> regRdValid) else $error("read not answered");
	a_rd_idle: assert property (!regRead |=> !regRdValid && regRdData == 8'h00) else $error("stray read data");
	a_rd_miss: assert property (regRead && !(regAddr inside {[12'h052:12'h05E]})
		|=> regRdMiss && regRdData == 8'h00) else $error("unmapped read not refused");
	a_rd_hit: assert property (regRead && regAddr inside {[12'h052:12'h05E]} |=> !regRdMiss)
		else $error("mapped read flagged as miss");
	a_gain_reserved: assert property (regRead && regAddr inside {12'h053, 12'h054, 12'h056, 12'h057,
		12'h059, 12'h05A, 12'h05C, 12'h05D} |=> regRdData[7] == 1'b0 && regRdData[3] == 1'b0)
		else $error("gain reserved bit set");
	a_en_reserved: assert property (regRead && regAddr inside {12'h052, 12'h055, 12'h058, 12'h05B,
		12'h05E} |=> regRdData[7] == 1'b0) else $error("enable reserved bit set");

	// ----------------------------------------
	// mode apply
	// ----------------------------------------
	a_apply_mode: assert property (applyStrobe && applyMode inside {[4'h6:4'hA]}
		|=> activeMode == $past(applyMode) && !applyMiss) else $error("applied mode not shown");
	a_apply_refuse: assert property (applyStrobe && !(applyMode inside {[4'h6:4'hA]})
		|=> applyMiss && $stable(activeProfile) && $stable(activeMode)) else $error("bad mode not refused");
	a_profile_hold: assert property (!applyStrobe |=> $stable(activeProfile) && !applyMiss)
		else $error("profile moved without apply");
	a_m10_gains: assert property (applyStrobe && applyMode == 4'hA
		|=> activeProfile[11:0] == $past(activeProfile[11:0])) else $error("mode ten touched gains");

	// main scenarios reached
	c_apply_ten: cover property (applyStrobe && applyMode == 4'hA);
	c_miss: cover property (regRead && regAddr == 12'h05F);
	c_wr_rd: cover property (regWrite ##2 regRead);
endmodule

bind rx_mode_profile_regs rx_mode_profile_regs_chk u_chk (.core_clk(core_clk), .reset(reset),
	.regAddr(regAddr), .regWrite(regWrite), .regWrData(regWrData), .regRead(regRead),
	.regRdData(regRdData), .regRdValid(regRdValid), .regRdMiss(regRdMiss), .applyStrobe(applyStrobe),
	.applyMode(applyMode), .activeProfile(activeProfile), .activeMode(activeMode), .applyMiss(applyMiss));

`default_nettype wire

// ==== verification/rx_mode_profile_regs_tb.sv ====
// self-checking testbench for the receiver mode profile bank
`default_nettype none

module rx_mode_profile_regs_tb
	import rx_profile_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

	// ----------------------------------------
	// signals and expectations
	// ----------------------------------------
	logic      core_clk    = 1'b0;    // 250 MHz clock
	logic      reset       = 1'b1;    // synchronous reset
	reg_addr_t regAddr     = '0;      // register address
	logic      regWrite    = 1'b0;    // write pulse
	reg_data_t regWrData   = '0;      // write byte
	logic      regRead     = 1'b0;    // read pulse
	reg_data_t regRdData;             // read byte
	logic      regRdValid;            // read answer
	logic      regRdMiss;             // unmapped read
	logic      applyStrobe = 1'b0;    // apply pulse
	mode_num_t applyMode   = '0;      // mode to apply
	profile_s  activeProfile;         // applied profile
	mode_num_t activeMode;            // applied mode
	logic      applyMiss;             // refused apply
	int        n_errors    = 0;       // mismatches
	int        num_checks  = 0;       // comparisons
	reg_data_t shadow [13];           // expected register contents
	profile_s  expProf     = '0;      // expected applied profile
	mode_num_t expMode     = '0;      // expected applied mode
	localparam reg_data_t RST_TAB [13] = '{8'h68, 8'h44, 8'h44, 8'h64, 8'h44, 8'h44, 8'h52,
		8'h44, 8'h44, 8'h51, 8'h44, 8'h44, 8'h7F};

	always #2 core_clk = ~core_clk;

	rx_mode_profile_regs u_dut (.core_clk(core_clk), .reset(reset), .regAddr(regAddr), .regWrite(regWrite),
		.regWrData(regWrData), .regRead(regRead), .regRdData(regRdData), .regRdValid(regRdValid),
		.regRdMiss(regRdMiss), .applyStrobe(applyStrobe), .applyMode(applyMode),
		.activeProfile(activeProfile), .activeMode(activeMode), .applyMiss(applyMiss));

	// ----------------------------------------
	// shared tasks
	// ----------------------------------------
	// count a comparison and report a mismatch
	task automatic check(input bit ok, input string msg);
		num_checks++;
		if (!ok) begin
			n_errors++;
			$display("CHECK FAILED at %0t: %s", $time, msg);
		end
	endtask

	// one write; shadow keeps only the writable bits
	task automatic reg_wr(input reg_addr_t a, input reg_data_t d);
		int i;
		i = int'(a) - 'h52;
		@(posedge core_clk);
		#1 regAddr = a;
		regWrData = d;
		regWrite = 1'b1;
		@(posedge core_clk);
		#1 regWrite = 1'b0;
		if (i >= 0 && i < 13) begin
			shadow[i] = d & ((i % 3 == 0) ? 8'h7F : 8'h77);
		end
	endtask

	// one read, answer judged one cycle later
	task automatic reg_rd(input reg_addr_t a, input reg_data_t exp, input logic miss);
		@(posedge core_clk);
		#1 regAddr = a;
		regRead = 1'b1;
		@(posedge core_clk);
		#1 regRead = 1'b0;
		check(regRdValid === 1'b1 && regRdData === exp && regRdMiss === miss, $sformatf("read %0h", a));
	endtask

	// one apply; mode ten leaves the gains where they were
	task automatic apply(input mode_num_t m);
		int i;
		i = (int'(m) - 6) * 3;
		@(posedge core_clk);
		#1 applyMode = m;
		applyStrobe = 1'b1;
		@(posedge core_clk);
		#1 applyStrobe = 1'b0;
		if (m >= 4'h6 && m <= 4'hA) begin
			expMode = m;
			expProf.pathEn = shadow[i][6:0];
			if (m != 4'hA) begin
				expProf.chanOneGain = shadow[i+1][6:4];
				expProf.chanTwoGain = shadow[i+1][2:0];
				expProf.chanThreeGain = shadow[i+2][6:4];
				expProf.chanFourGain = shadow[i+2][2:0];
			end
		end
		check(activeProfile === expProf && activeMode === expMode && applyMiss === (m < 4'h6 || m > 4'hA),
			$sformatf("apply %0d", m));
	endtask

	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	// every byte at its default, nothing applied yet
	task automatic test_reset_values();
		check(activeProfile === 19'h00000 && activeMode === 4'h0, "idle profile");
		for (int i = 0; i < 13; i++) begin
			reg_rd(12'h052 + 12'(i), RST_TAB[i], 1'b0);
		end
	endtask

	// every mode applied, then out-of-range modes refused
	task automatic test_apply();
		for (int m = 6; m <= 10; m++) begin
			apply(4'(m));
		end
		apply(4'h5);
		apply(4'hB);
		apply(4'h0);
	endtask

	// a stored write only shows once applied
	task automatic test_profile_write();
		reg_wr(12'h056, 8'h35);
		check(activeProfile === expProf, "profile moved on write");
		apply(4'h7);
		reg_wr(12'h055, 8'hFF);
		reg_rd(12'h055, 8'h7F, 1'b0);
		apply(4'h7);
		apply(4'hA);
	endtask

	// unmapped places read zero and take no write
	task automatic test_unmapped();
		reg_wr(12'h05F, 8'hFF);
		reg_rd(12'h05F, 8'h00, 1'b1);
		reg_rd(12'h051, 8'h00, 1'b1);
		reg_rd(12'hFFF, 8'h00, 1'b1);
		reg_rd(12'h05E, shadow[12], 1'b0);
	endtask

	// each byte in turn cleared, then filled; reserved bits stay zero
	task automatic test_write_all();
		for (int i = 0; i < 13; i++) begin
			reg_wr(12'h052 + 12'(i), 8'h00);
			reg_rd(12'h052 + 12'(i), 8'h00, 1'b0);
			reg_wr(12'h052 + 12'(i), 8'hFF - 8'(i));
			reg_rd(12'h052 + 12'(i), shadow[i], 1'b0);
		end
		apply(4'h9);
	endtask

	// reset in mid-run restores defaults and idles the outputs
	task automatic test_mid_reset();
		@(posedge core_clk);
		#1 reset = 1'b1;
		repeat (2) @(posedge core_clk);
		#1 reset = 1'b0;
		shadow = RST_TAB;
		expProf = '0;
		expMode = '0;
		check(activeProfile === 19'h00000 && activeMode === 4'h0, "profile after reset");
		reg_rd(12'h05B, 8'h51, 1'b0);
		apply(4'h8);
	endtask

	// ----------------------------------------
	// verdict and run control
	// ----------------------------------------
	task automatic test_done();
		$display("checks %0d, errors %0d", num_checks, n_errors);
		if (n_errors == 0 && num_checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	// watchdog well beyond the expected run
	initial begin
		repeat (5000) @(posedge core_clk);
		n_errors++;
		test_done();
	end

	// main sequence
	initial begin
		shadow = RST_TAB;
		repeat (6) @(posedge core_clk);
		#1 reset = 1'b0;
		test_reset_values();
		test_apply();
		test_profile_write();
		test_unmapped();
		test_write_all();
		test_mid_reset();
		test_done();
	end
endmodule

`default_nettype wire
